// ===== clock_output_ctrl_smbus.sv
// Contract
// - Serial port takes only block writes; indexed access is unsupported.
// - Bytes go lowest first, each MSB first; stop after any whole byte.
// - Device answers address byte 11010010, a write to the clock device.
// - Transfer is valid once the count byte acknowledge is clocked back.
// - Configuration bits take defaults at power-up; no access is needed.
// - Mode pin high: shared pin is input, buffers follow it, PCI halves it.
// - Mode pin low: 66 MHz groups internal, PCI clocks at 33 MHz.
// - Frequency selects set CPU clock: 66, 100, 200, 133 MHz.
// - Mid mode with selects 00 floats every output; 10 and 11 reserved.
// - Test mode divides test clock: CPU/48 half, 66 quarter, PCI eighth.
// - Test modes reuse the 200 MHz CPU divider settings.
// - Power-down: CPU true at double current, complement floats, rest low.
// - CPU stop: true runs, complement stops, floating if PCI stop too.
// - PCI stop turns off stoppable PCI; other groups keep running.
// - Control bit 7 enables spread modulation; default off.
// - Control bit 5 picks shared output 66 or 48 MHz; default 66.
// - Control bit 4 reads the live CPU stop pin level.
// - Control bit 3 stops the seven stoppable PCI clocks by software.
// - Bits 2 to 0 read latched straps; bit 6 reads zero.
// - Straps sampled while power-good is low; later changes ignored.
`timescale 1ns/1ps
module clock_output_ctrl_smbus (
	// Clock and reset.
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// Strap pins and power-good strobe.
	input  wire logic       mode_select_pin_hi_i,
	input  wire logic       mode_select_pin_mid_i,
	input  wire logic       freq_select_hi_i,
	input  wire logic       freq_select_lo_i,
	input  wire logic       power_good_strobe_n_i,
	// Power management pins.
	input  wire logic       power_down_n_i,
	input  wire logic       cpu_stop_n_i,
	input  wire logic       pci_stop_n_i,
	// Serial bus pins.
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Frequency plan.
	output logic [1:0]      cpu_freq_sel_o,
	output logic            test_mode_o,
	output logic            outputs_hiz_o,
	output logic            reserved_mode_o,
	output logic            external_66_input_o,
	output logic [3:0]      cpu_div_o,
	output logic [3:0]      fixed_66_div_o,
	output logic [3:0]      pci_div_o,
	output logic [3:0]      reference_div_o,
	output logic [3:0]      usb_div_o,
	// Output group drive states.
	output clock_output_ctrl_pkg::drive_t cpu_true_drv_o,
	output clock_output_ctrl_pkg::drive_t cpu_comp_drv_o,
	output clock_output_ctrl_pkg::drive_t fixed_66_drv_o,
	output clock_output_ctrl_pkg::drive_t buffered_66_drv_o,
	output clock_output_ctrl_pkg::drive_t pci_free_drv_o,
	output clock_output_ctrl_pkg::drive_t pci_stoppable_drv_o,
	output clock_output_ctrl_pkg::drive_t usb_pixel_drv_o,
	output clock_output_ctrl_pkg::drive_t reference_drv_o,
	output logic            osc_vco_en_o,
	// Configuration outputs.
	output logic            spread_en_o,
	output logic            video_hub_48_o,
	output logic [7:0]      control_byte_o,
	output logic            transfer_valid_o
);

	logic [9:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       pg_n_s;
	logic       pd_n_s;
	logic       cpu_stop_n_s;
	logic       pci_stop_n_s;
	logic [3:0] straps_s;
	logic [3:0] strap_q;
	logic       locked_q;
	logic       spread_q;
	logic       vch_q;
	logic       pci_sw_stop_q;
	logic       byte_wr;
	logic [5:0] byte_idx;
	logic [7:0] byte_data;
	logic       mode_hi;
	logic       mode_mid;
	logic [1:0] fsel;
	logic       hiz_c;
	logic       test_c;
	logic       rsv_c;
	logic       float_c;
	logic       pci_off_c;
	logic [7:0] ctl_c;

	pin_sync #(
		.WIDTH (10)
	) u_pin_sync (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.async_i ({scl_i, sda_i, power_good_strobe_n_i, power_down_n_i,
			cpu_stop_n_i, pci_stop_n_i, mode_select_pin_mid_i,
			mode_select_pin_hi_i, freq_select_hi_i, freq_select_lo_i}),
		.sync_o  (pins_s)
	);

	assign scl_s        = pins_s[9];
	assign sda_s        = pins_s[8];
	assign pg_n_s       = pins_s[7];
	assign pd_n_s       = pins_s[6];
	assign cpu_stop_n_s = pins_s[5];
	assign pci_stop_n_s = pins_s[4];
	assign straps_s     = pins_s[3:0];

	smbus_block_write_slave u_slave (
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.scl_i       (scl_s),
		.sda_i       (sda_s),
		.sda_o       (sda_o),
		.sda_oe_o    (sda_oe_o),
		.byte_wr_o   (byte_wr),
		.byte_idx_o  (byte_idx),
		.byte_data_o (byte_data),
		.valid_o     (transfer_valid_o)
	);

	// Straps are caught once while power-good is low, then frozen.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			strap_q  <= clock_output_ctrl_pkg::STRAP_RST;
			locked_q <= 1'h0;
		end
		else if (!locked_q && !pg_n_s)
		begin
			strap_q  <= straps_s;
			locked_q <= 1'h1;
		end
	end

	assign mode_mid = strap_q[3];
	assign mode_hi  = strap_q[2];
	assign fsel     = strap_q[1:0];
	assign hiz_c    = mode_mid && fsel == 2'h0;
	assign test_c   = mode_mid && fsel == 2'h1;
	assign rsv_c    = mode_mid && fsel[1];
	assign float_c  = hiz_c || rsv_c;

	// Only the control byte is kept; later bytes within the count are acknowledged and dropped.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			spread_q      <= clock_output_ctrl_pkg::SPREAD_RST;
			vch_q         <= clock_output_ctrl_pkg::VCH_RST;
			pci_sw_stop_q <= clock_output_ctrl_pkg::PCI_SW_STOP_RST;
		end
		else if (byte_wr && byte_idx == clock_output_ctrl_pkg::CTRL_BYTE_IDX)
		begin
			spread_q      <= byte_data[clock_output_ctrl_pkg::SPREAD_BIT];
			vch_q         <= byte_data[clock_output_ctrl_pkg::VCH_BIT];
			pci_sw_stop_q <= byte_data[clock_output_ctrl_pkg::PCI_SW_STOP_BIT];
		end
	end

	always_comb
	begin
		ctl_c = 8'h00;
		ctl_c[clock_output_ctrl_pkg::SPREAD_BIT]      = spread_q;
		ctl_c[clock_output_ctrl_pkg::VCH_BIT]         = vch_q;
		ctl_c[clock_output_ctrl_pkg::CPU_STOP_BIT]    = cpu_stop_n_s;
		ctl_c[clock_output_ctrl_pkg::PCI_SW_STOP_BIT] = pci_sw_stop_q;
		ctl_c[clock_output_ctrl_pkg::STRAP_MODE_BIT]  = mode_hi;
		ctl_c[clock_output_ctrl_pkg::STRAP_FSH_BIT]   = fsel[1];
		ctl_c[clock_output_ctrl_pkg::STRAP_FSL_BIT]   = fsel[0];
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			control_byte_o <= 8'h00;
			spread_en_o    <= clock_output_ctrl_pkg::SPREAD_RST;
			video_hub_48_o <= clock_output_ctrl_pkg::VCH_RST;
		end
		else
		begin
			control_byte_o <= ctl_c;
			spread_en_o    <= spread_q;
			video_hub_48_o <= vch_q;
		end
	end

	// Frequency plan from the latched straps.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cpu_freq_sel_o      <= 2'h0;
			test_mode_o         <= 1'h0;
			outputs_hiz_o       <= 1'h0;
			reserved_mode_o     <= 1'h0;
			external_66_input_o <= 1'h0;
			cpu_div_o           <= clock_output_ctrl_pkg::DIV_NORM;
			fixed_66_div_o      <= clock_output_ctrl_pkg::DIV_NORM;
			pci_div_o           <= clock_output_ctrl_pkg::DIV_NORM_PCI;
			reference_div_o     <= clock_output_ctrl_pkg::DIV_NORM;
			usb_div_o           <= clock_output_ctrl_pkg::DIV_NORM;
		end
		else
		begin
			test_mode_o         <= test_c;
			outputs_hiz_o       <= hiz_c;
			reserved_mode_o     <= rsv_c;
			external_66_input_o <= mode_hi && !mode_mid;
			if (test_c)
			begin
				cpu_freq_sel_o  <= clock_output_ctrl_pkg::CPU_SEL_200;
				cpu_div_o       <= clock_output_ctrl_pkg::DIV_TEST_CPU;
				fixed_66_div_o  <= clock_output_ctrl_pkg::DIV_TEST_66;
				pci_div_o       <= clock_output_ctrl_pkg::DIV_TEST_PCI;
				reference_div_o <= clock_output_ctrl_pkg::DIV_TEST_REF;
				usb_div_o       <= clock_output_ctrl_pkg::DIV_TEST_48;
			end
			else
			begin
				cpu_freq_sel_o  <= fsel;
				cpu_div_o       <= clock_output_ctrl_pkg::DIV_NORM;
				fixed_66_div_o  <= clock_output_ctrl_pkg::DIV_NORM;
				pci_div_o       <= clock_output_ctrl_pkg::DIV_NORM_PCI;
				reference_div_o <= clock_output_ctrl_pkg::DIV_NORM;
				usb_div_o       <= clock_output_ctrl_pkg::DIV_NORM;
			end
		end
	end

	assign pci_off_c = !pci_stop_n_s || pci_sw_stop_q;

	// Output gating from the power management pins.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cpu_true_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			cpu_comp_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			fixed_66_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			buffered_66_drv_o   <= clock_output_ctrl_pkg::DRV_RUN;
			pci_free_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			pci_stoppable_drv_o <= clock_output_ctrl_pkg::DRV_RUN;
			usb_pixel_drv_o     <= clock_output_ctrl_pkg::DRV_RUN;
			reference_drv_o     <= clock_output_ctrl_pkg::DRV_RUN;
			osc_vco_en_o        <= 1'h1;
		end
		else if (float_c)
		begin
			cpu_true_drv_o      <= clock_output_ctrl_pkg::DRV_FLOAT;
			cpu_comp_drv_o      <= clock_output_ctrl_pkg::DRV_FLOAT;
			fixed_66_drv_o      <= clock_output_ctrl_pkg::DRV_FLOAT;
			buffered_66_drv_o   <= clock_output_ctrl_pkg::DRV_FLOAT;
			pci_free_drv_o      <= clock_output_ctrl_pkg::DRV_FLOAT;
			pci_stoppable_drv_o <= clock_output_ctrl_pkg::DRV_FLOAT;
			usb_pixel_drv_o     <= clock_output_ctrl_pkg::DRV_FLOAT;
			reference_drv_o     <= clock_output_ctrl_pkg::DRV_FLOAT;
			osc_vco_en_o        <= 1'h1;
		end
		else if (!pd_n_s)
		begin
			cpu_true_drv_o      <= clock_output_ctrl_pkg::DRV_IREF2;
			cpu_comp_drv_o      <= clock_output_ctrl_pkg::DRV_FLOAT;
			fixed_66_drv_o      <= clock_output_ctrl_pkg::DRV_LOW;
			buffered_66_drv_o   <= clock_output_ctrl_pkg::DRV_LOW;
			pci_free_drv_o      <= clock_output_ctrl_pkg::DRV_LOW;
			pci_stoppable_drv_o <= clock_output_ctrl_pkg::DRV_LOW;
			usb_pixel_drv_o     <= clock_output_ctrl_pkg::DRV_LOW;
			reference_drv_o     <= clock_output_ctrl_pkg::DRV_LOW;
			osc_vco_en_o        <= 1'h0;
		end
		else
		begin
			cpu_true_drv_o <= clock_output_ctrl_pkg::DRV_RUN;
			if (cpu_stop_n_s)
				cpu_comp_drv_o <= clock_output_ctrl_pkg::DRV_RUN;
			else if (!pci_stop_n_s)
				cpu_comp_drv_o <= clock_output_ctrl_pkg::DRV_FLOAT;
			else
				cpu_comp_drv_o <= clock_output_ctrl_pkg::DRV_LOW;
			fixed_66_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			buffered_66_drv_o   <= clock_output_ctrl_pkg::DRV_RUN;
			pci_free_drv_o      <= clock_output_ctrl_pkg::DRV_RUN;
			pci_stoppable_drv_o <= pci_off_c ?
				clock_output_ctrl_pkg::DRV_LOW :
				clock_output_ctrl_pkg::DRV_RUN;
			usb_pixel_drv_o     <= clock_output_ctrl_pkg::DRV_RUN;
			reference_drv_o     <= clock_output_ctrl_pkg::DRV_RUN;
			osc_vco_en_o        <= 1'h1;
		end
	end

	property p_hiz_all;
		@(posedge clock_i) disable iff (!nrst_i)
		hiz_c |=> outputs_hiz_o &&
			cpu_true_drv_o == clock_output_ctrl_pkg::DRV_FLOAT &&
			reference_drv_o == clock_output_ctrl_pkg::DRV_FLOAT;
	endproperty
	a_hiz_all: assert property (p_hiz_all)
		else $error("outputs not floated in high-impedance mode");

	property p_power_down;
		@(posedge clock_i) disable iff (!nrst_i)
		(!pd_n_s && !float_c) |=>
			cpu_true_drv_o == clock_output_ctrl_pkg::DRV_IREF2 &&
			cpu_comp_drv_o == clock_output_ctrl_pkg::DRV_FLOAT &&
			fixed_66_drv_o == clock_output_ctrl_pkg::DRV_LOW &&
			!osc_vco_en_o;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("power-down gating wrong");

	property p_cpu_stop;
		@(posedge clock_i) disable iff (!nrst_i)
		(pd_n_s && !float_c && !cpu_stop_n_s) |=>
			cpu_true_drv_o == clock_output_ctrl_pkg::DRV_RUN &&
			cpu_comp_drv_o == ($past(pci_stop_n_s) ?
			clock_output_ctrl_pkg::DRV_LOW : clock_output_ctrl_pkg::DRV_FLOAT);
	endproperty
	a_cpu_stop: assert property (p_cpu_stop)
		else $error("CPU stop gating wrong");

	property p_pci_stop;
		@(posedge clock_i) disable iff (!nrst_i)
		(pd_n_s && !float_c && !pci_stop_n_s) |=>
			pci_stoppable_drv_o == clock_output_ctrl_pkg::DRV_LOW &&
			pci_free_drv_o == clock_output_ctrl_pkg::DRV_RUN &&
			usb_pixel_drv_o == clock_output_ctrl_pkg::DRV_RUN;
	endproperty
	a_pci_stop: assert property (p_pci_stop)
		else $error("PCI stop gating wrong");

	property p_test_div;
		@(posedge clock_i) disable iff (!nrst_i)
		test_c |=> test_mode_o &&
			cpu_div_o == clock_output_ctrl_pkg::DIV_TEST_CPU &&
			fixed_66_div_o == clock_output_ctrl_pkg::DIV_TEST_66 &&
			pci_div_o == clock_output_ctrl_pkg::DIV_TEST_PCI;
	endproperty
	a_test_div: assert property (p_test_div)
		else $error("test mode dividers wrong");

	property p_test_sel;
		@(posedge clock_i) disable iff (!nrst_i)
		test_mode_o |-> cpu_freq_sel_o == clock_output_ctrl_pkg::CPU_SEL_200;
	endproperty
	a_test_sel: assert property (p_test_sel)
		else $error("test mode not on the 200 MHz setting");

	property p_strap_frozen;
		@(posedge clock_i) disable iff (!nrst_i)
		locked_q |=> $stable(strap_q);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen)
		else $error("straps changed after capture");

	property p_spread_load;
		@(posedge clock_i) disable iff (!nrst_i)
		(byte_wr && byte_idx == clock_output_ctrl_pkg::CTRL_BYTE_IDX) |=>
			##1 spread_en_o == $past(byte_data[7], 2);
	endproperty
	a_spread_load: assert property (p_spread_load)
		else $error("spread enable not loaded from control byte");

	property p_stop_readback;
		@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |->
			control_byte_o[clock_output_ctrl_pkg::CPU_STOP_BIT] ==
			$past(cpu_stop_n_s) &&
			!control_byte_o[clock_output_ctrl_pkg::RSVD_BIT];
	endproperty
	a_stop_readback: assert property (p_stop_readback)
		else $error("CPU stop readback wrong");

endmodule

// ===== clock_output_ctrl_pkg.sv
package clock_output_ctrl_pkg;

	// Serial slave identity and transfer limits.
	localparam logic [6:0] SMBUS_ADDR    = 7'h69;
	localparam logic [7:0] CMD_CODE      = 8'h00;
	localparam logic [7:0] COUNT_MIN     = 8'h01;
	localparam logic [7:0] COUNT_MAX     = 8'h20;
	localparam logic [5:0] CTRL_BYTE_IDX = 6'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT      = 4'h9;

	// Control byte field positions.
	localparam int SPREAD_BIT      = 7;
	localparam int RSVD_BIT        = 6;
	localparam int VCH_BIT         = 5;
	localparam int CPU_STOP_BIT    = 4;
	localparam int PCI_SW_STOP_BIT = 3;
	localparam int STRAP_MODE_BIT  = 2;
	localparam int STRAP_FSH_BIT   = 1;
	localparam int STRAP_FSL_BIT   = 0;

	// Power-up values.
	localparam logic       SPREAD_RST      = 1'h0;
	localparam logic       VCH_RST         = 1'h0;
	localparam logic       PCI_SW_STOP_RST = 1'h0;
	localparam logic [3:0] STRAP_RST       = 4'h0;

	// CPU frequency code used by the test modes.
	localparam logic [1:0] CPU_SEL_200 = 2'h2;

	// Divide ratios of each output group.
	localparam logic [3:0] DIV_NORM     = 4'h1;
	localparam logic [3:0] DIV_NORM_PCI = 4'h2;
	localparam logic [3:0] DIV_TEST_CPU = 4'h2;
	localparam logic [3:0] DIV_TEST_66  = 4'h4;
	localparam logic [3:0] DIV_TEST_PCI = 4'h8;
	localparam logic [3:0] DIV_TEST_REF = 4'h1;
	localparam logic [3:0] DIV_TEST_48  = 4'h2;

	typedef enum logic [1:0] {DRV_RUN, DRV_LOW, DRV_FLOAT, DRV_IREF2} drive_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_COUNT, ST_DATA, ST_SKIP
	} smb_state_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	generate
		if (WIDTH < 1)
		begin : g_check
			$error("pin_sync needs a width of at least one");
		end
	endgenerate

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			// Idle high, so no false edge or strobe follows reset.
			meta_q <= '1;
			sync_o <= '1;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

// ===== smbus_block_write_slave.sv
`timescale 1ns/1ps
module smbus_block_write_slave (
	// Clock and reset.
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// Synchronised bus levels.
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// Data line driver.
	output logic            sda_o,
	output logic            sda_oe_o,
	// Received data bytes.
	output logic            byte_wr_o,
	output logic [5:0]      byte_idx_o,
	output logic [7:0]      byte_data_o,
	output logic            valid_o
);

	clock_output_ctrl_pkg::smb_state_t state_q;
	logic       scl_q;
	logic       sda_q;
	logic [7:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic       ack_q;
	logic       cmd_ok_q;
	logic [5:0] count_q;
	logic [5:0] idx_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       active;
	logic       in_range;
	logic [7:0] byte_c;

	assign sda_o    = 1'h0;
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
	assign byte_c   = {shift_q[6:0], sda_i};
	assign active   = state_q != clock_output_ctrl_pkg::ST_IDLE &&
		state_q != clock_output_ctrl_pkg::ST_SKIP;
	assign in_range = byte_c >= clock_output_ctrl_pkg::COUNT_MIN &&
		byte_c <= clock_output_ctrl_pkg::COUNT_MAX;

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Only the fixed block write sequence is decoded.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q     <= clock_output_ctrl_pkg::ST_IDLE;
			shift_q     <= 8'h00;
			bit_cnt_q   <= 4'h0;
			ack_q       <= 1'h0;
			cmd_ok_q    <= 1'h0;
			count_q     <= 6'h00;
			idx_q       <= 6'h00;
			sda_oe_o    <= 1'h0;
			byte_wr_o   <= 1'h0;
			byte_idx_o  <= 6'h00;
			byte_data_o <= 8'h00;
			valid_o     <= 1'h0;
		end
		else
		begin
			byte_wr_o <= 1'h0;
			valid_o   <= 1'h0;
			if (start_c)
			begin
				state_q   <= clock_output_ctrl_pkg::ST_ADDR;
				bit_cnt_q <= 4'h0;
				idx_q     <= 6'h00;
				sda_oe_o  <= 1'h0;
			end
			else if (stop_c)
			begin
				state_q  <= clock_output_ctrl_pkg::ST_IDLE;
				sda_oe_o <= 1'h0;
			end
			else if (active && scl_rise &&
				bit_cnt_q < clock_output_ctrl_pkg::BITS_PER_BYTE)
			begin
				shift_q   <= byte_c;
				bit_cnt_q <= bit_cnt_q + 4'h1;
				if (bit_cnt_q == clock_output_ctrl_pkg::BITS_PER_BYTE - 4'h1)
				begin
					case (state_q)
						clock_output_ctrl_pkg::ST_ADDR:
							ack_q <= byte_c ==
								{clock_output_ctrl_pkg::SMBUS_ADDR, 1'h0};
						clock_output_ctrl_pkg::ST_CMD:
						begin
							ack_q    <= 1'h1;
							cmd_ok_q <= byte_c == clock_output_ctrl_pkg::CMD_CODE;
						end
						clock_output_ctrl_pkg::ST_COUNT:
						begin
							ack_q    <= 1'h1;
							cmd_ok_q <= cmd_ok_q && in_range;
							count_q  <= in_range ? byte_c[5:0] : 6'h00;
						end
						clock_output_ctrl_pkg::ST_DATA:
						begin
							ack_q       <= idx_q < count_q;
							byte_wr_o   <= cmd_ok_q && idx_q < count_q;
							byte_idx_o  <= idx_q;
							byte_data_o <= byte_c;
						end
						default:
							ack_q <= 1'h0;
					endcase
				end
			end
			else if (active && scl_fall &&
				bit_cnt_q == clock_output_ctrl_pkg::BITS_PER_BYTE)
			begin
				sda_oe_o  <= ack_q;
				bit_cnt_q <= clock_output_ctrl_pkg::ACK_SLOT;
			end
			else if (active && scl_fall &&
				bit_cnt_q == clock_output_ctrl_pkg::ACK_SLOT)
			begin
				sda_oe_o  <= 1'h0;
				bit_cnt_q <= 4'h0;
				case (state_q)
					clock_output_ctrl_pkg::ST_ADDR:
						state_q <= ack_q ? clock_output_ctrl_pkg::ST_CMD :
							clock_output_ctrl_pkg::ST_SKIP;
					clock_output_ctrl_pkg::ST_CMD:
						state_q <= clock_output_ctrl_pkg::ST_COUNT;
					clock_output_ctrl_pkg::ST_COUNT:
					begin
						state_q <= clock_output_ctrl_pkg::ST_DATA;
						valid_o <= cmd_ok_q;
					end
					clock_output_ctrl_pkg::ST_DATA:
					begin
						state_q <= ack_q ? clock_output_ctrl_pkg::ST_DATA :
							clock_output_ctrl_pkg::ST_SKIP;
						idx_q   <= idx_q + 6'h01;
					end
					default:
						state_q <= clock_output_ctrl_pkg::ST_IDLE;
				endcase
			end
		end
	end

	property p_ack_slot;
		@(posedge clock_i) disable iff (!nrst_i)
		sda_oe_o |-> bit_cnt_q == clock_output_ctrl_pkg::ACK_SLOT;
	endproperty
	a_ack_slot: assert property (p_ack_slot)
		else $error("data line driven outside the ninth clock");

	property p_valid_after_count;
		@(posedge clock_i) disable iff (!nrst_i)
		valid_o |-> $past(state_q) == clock_output_ctrl_pkg::ST_COUNT &&
			state_q == clock_output_ctrl_pkg::ST_DATA && !sda_oe_o;
	endproperty
	a_valid_after_count: assert property (p_valid_after_count)
		else $error("transfer marked valid at the wrong time");

	property p_byte_complete;
		@(posedge clock_i) disable iff (!nrst_i)
		byte_wr_o |-> bit_cnt_q == clock_output_ctrl_pkg::BITS_PER_BYTE &&
			state_q == clock_output_ctrl_pkg::ST_DATA;
	endproperty
	a_byte_complete: assert property (p_byte_complete)
		else $error("data byte written before eight bits arrived");

endmodule

// ===== smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
	// Clock and the device pull-down.
	input  wire logic       clock_i,
	input  wire logic       sda_oe_i,
	// Bus lines and acknowledge count.
	output logic            scl_o,
	output logic            sda_o,
	output logic [3:0]      n_ack_o
);
	initial
	begin
		scl_o = 1'h1;
		sda_o = 1'h1;
		n_ack_o = 4'h0;
	end
	task half;
		repeat (10) @(posedge clock_i);
	endtask
	task start_c;
		sda_o <= 1'h0;
		half;
		scl_o <= 1'h0;
		half;
	endtask
	task stop_c;
		sda_o <= 1'h0;
		half;
		scl_o <= 1'h1;
		half;
		sda_o <= 1'h1;
		half;
	endtask
	// Sends one byte and counts the device acknowledge.
	task put_byte(input logic [7:0] b);
		for (int i = 9; i > 0; i--)
		begin
			sda_o <= (i > 1) ? b[i-2] : 1'h1;
			half;
			scl_o <= 1'h1;
			half;
			if (i == 1 && sda_oe_i === 1'h1)
				n_ack_o <= n_ack_o + 4'h1;
			scl_o <= 1'h0;
			half;
		end
	endtask
endmodule

// ===== clock_output_ctrl_smbus_tb.sv
`timescale 1ns/1ps
module clock_output_ctrl_smbus_tb;
	logic        clock_i = 1'h0;
	logic        nrst_i = 1'h0;
	logic [7:0]  pins = 8'h0F;
	logic        scl;
	logic        sda_h;
	logic        oe;
	logic        valid;
	logic [7:0]  cb;
	logic [1:0]  t;
	logic [1:0]  c;
	logic [1:0]  n_val = 2'h0;
	logic [17:0] q[$];
	event        look;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          seed = 32'hc09c;
	logic [7:0]  ctl;
	logic [7:0]  d;
	logic [2:0]  r;
	logic [3:0]  acks = 4'h0;
	logic [1:0]  vals = 2'h0;
	wire         sda = sda_h & ~oe;
	smbus_host_model u_smbus_host_model (.clock_i(clock_i),
		.sda_oe_i(oe), .scl_o(scl), .sda_o(sda_h), .n_ack_o());
	clock_output_ctrl_smbus u_clock_output_ctrl_smbus (.clock_i(clock_i),
		.nrst_i(nrst_i), .mode_select_pin_hi_i(pins[7]),
		.mode_select_pin_mid_i(pins[6]), .freq_select_hi_i(pins[5]),
		.freq_select_lo_i(pins[4]), .power_good_strobe_n_i(pins[3]),
		.power_down_n_i(pins[2]), .cpu_stop_n_i(pins[1]),
		.pci_stop_n_i(pins[0]), .scl_i(scl), .sda_i(sda), .sda_o(),
		.sda_oe_o(oe), .cpu_freq_sel_o(), .test_mode_o(),
		.outputs_hiz_o(), .reserved_mode_o(), .external_66_input_o(),
		.cpu_div_o(), .fixed_66_div_o(), .pci_div_o(),
		.reference_div_o(), .usb_div_o(), .cpu_true_drv_o(t),
		.cpu_comp_drv_o(c), .fixed_66_drv_o(), .buffered_66_drv_o(),
		.pci_free_drv_o(), .pci_stoppable_drv_o(), .usb_pixel_drv_o(),
		.reference_drv_o(), .osc_vco_en_o(), .spread_en_o(),
		.video_hub_48_o(), .control_byte_o(cb), .transfer_valid_o(valid));
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i)
		if (valid === 1'h1)
			n_val <= n_val + 2'h1;
	task wrap_up;
		if (q.size() != 0)
			n_mismatch++;
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(input logic [17:0] e, input logic [17:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	always @(look)
		cmp(q.pop_front(), {cb, u_smbus_host_model.n_ack_o, n_val, t, c});
	// Notes the expected status once pin effects have settled.
	task note(input logic [1:0] tt, input logic [1:0] cc);
		repeat (6) @(posedge clock_i);
		q.push_back({ctl, acks, vals, tt, cc});
		-> look;
	endtask
	task wr(input logic [39:0] b, input int n);
		u_smbus_host_model.start_c;
		for (int i = 0; i < n; i++)
			u_smbus_host_model.put_byte(b[39-8*i -: 8]);
		u_smbus_host_model.stop_c;
	endtask
	task rst(input logic [7:0] p);
		nrst_i <= 1'h0;
		pins   <= p;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'h1;
		repeat (5) @(posedge clock_i);
	endtask
	initial
	begin
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'h1;
		repeat (5) @(posedge clock_i);
		r = 3'($random(seed));
		pins <= {r[2], 1'h0, r[1:0], 4'h7};
		ctl = {5'h02, r};
		note(2'h0, 2'h0);
		pins <= {~r[2], 1'h0, ~r[1:0], 4'hF};
		note(2'h0, 2'h0);
		d = 8'($random(seed));
		wr({8'hD2, 8'h00, 8'h02, d, ~d}, 5);
		acks = acks + 4'h5;
		vals = vals + 2'h1;
		ctl = {d[7], 1'h0, d[5], 1'h1, d[3], r};
		note(2'h0, 2'h0);
		wr({8'hD3, 32'h0}, 1);
		wr({8'hD4, 32'h0}, 1);
		note(2'h0, 2'h0);
		wr({8'hD2, 8'h00, 8'h03, 16'h0}, 3);
		acks = acks + 4'h3;
		vals = vals + 2'h1;
		note(2'h0, 2'h0);
		wr({8'hD2, 8'h01, 8'h01, ~d, 8'h00}, 4);
		wr({8'hD2, 8'h00, 8'h21, ~d, 8'h00}, 4);
		acks = acks + 4'h7;
		note(2'h0, 2'h0);
		pins[1:0] <= 2'h0;
		ctl[4] = 1'h0;
		note(2'h0, 2'h2);
		pins[0] <= 1'h1;
		note(2'h0, 2'h1);
		pins[2] <= 1'h0;
		note(2'h3, 2'h2);
		rst(8'h47);
		ctl = 8'h10;
		note(2'h2, 2'h2);
		rst(8'h57);
		ctl = 8'h11;
		note(2'h0, 2'h0);
		@(posedge clock_i);
		wrap_up;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		wrap_up;
	end
endmodule
